// File: core/gac_pkg.sv
/*
  Package for the graphics aperture control block: register offsets, field
  positions, reset values, throttle timing, translation buffer sizes and the
  packed structs that carry lookup and fill traffic.
  Assumes a byte-addressed register port with 32-bit data words.
*/
package gac_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] GAC_OFF_APERTURE_BASE = 8'h10;
  localparam logic [7:0] GAC_OFF_PORT_CONTROL = 8'hb0;
  localparam logic [7:0] GAC_OFF_SIZE_SELECT = 8'hb4;

  // graphics_port_control fields
  localparam int GAC_CTL_SYNC_BIT = 13;
  localparam int GAC_CTL_THR_LSB = 8;
  localparam int GAC_CTL_TLB_BIT = 7;
  localparam logic [31:0] GAC_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] GAC_CTL_WMASK = 32'h0000_2380;

  // aperture_size_select fields
  localparam logic [7:0] GAC_SIZE_RESET = 8'h00;
  localparam logic [7:0] GAC_SIZE_WMASK = 8'h3f;

  // aperture base: bits 31:22 stored, 27:22 gated by the size mask
  localparam int GAC_BASE_LSB = 22;
  localparam int GAC_BASE_MASKED_MSB = 27;
  localparam logic [9:0] GAC_BASE_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // expedite throttle
  // ----------------------------------------------------------------------
  localparam logic [1:0] GAC_THR_NONE = 2'h0;
  localparam logic [1:0] GAC_THR_192_64 = 2'h2;
  localparam logic [7:0] GAC_THR_ON_CLKS = 8'hc0;   // 192 enabled clocks
  localparam logic [7:0] GAC_THR_OFF_CLKS = 8'h40;  // 64 masked clocks

  typedef enum logic [1:0] {
    GAC_TS_IDLE = 2'b00,
    GAC_TS_ON = 2'b01,
    GAC_TS_MASK = 2'b10
  } gac_thr_state_t;

  // ----------------------------------------------------------------------
  // translation buffer
  // ----------------------------------------------------------------------
  localparam int GAC_TLB_ENTRIES = 4;
  localparam int GAC_PAGE_W = 16;
  localparam int GAC_FRAME_W = 20;

  typedef struct packed {
    logic valid;
    logic [GAC_PAGE_W-1:0] page;
  } gac_lookup_t;

  typedef struct packed {
    logic valid;
    logic [GAC_PAGE_W-1:0] page;
    logic [GAC_FRAME_W-1:0] frame;
  } gac_fill_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic bypass;
    logic [GAC_FRAME_W-1:0] frame;
  } gac_answer_t;

endpackage

// File: core/gac_top.sv
/*
  Graphics aperture control: control and aperture size registers, posted
  aperture write synchronisation, expedite throttle timer, a small graphics
  translation lookaside buffer and the size-masked aperture base bits.
  Register map: graphics_port_control at 0xb0, aperture_size_select at 0xb4
  and the aperture base bits 31:22 at 0x10; unmapped words read as zero.
  Assumes a single-cycle register master that never issues read and write
  together, and a write buffer that reports whether aperture writes remain.
  Every input is taken as synchronous to ref_clk, and srst is synchronous
  and active high; every output comes straight from a flop, so consumers
  see all decisions one clock after the inputs that caused them.
*/
// The implementer's own choice: strobed register access.
module gac_top
  import gac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic aperture_writes_pending,
  input wire logic cpu_port_cycle_req,
  output logic cpu_port_cycle_go,
  output logic aperture_drain_req,
  input wire logic expedite_pending_raw,
  output logic expedite_pending,
  input wire gac_pkg::gac_lookup_t tlb_lookup,
  input wire gac_pkg::gac_fill_t tlb_fill,
  output gac_pkg::gac_answer_t tlb_answer,
  output logic [9:0] aperture_base_bits,
  output logic [5:0] aperture_size_mask,
  output logic graphics_translation_buffer_en
);
  import gac_pkg::*;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // one function for both read and write decoding keeps the two in step
  // byte lanes are not decoded: any address inside a word selects it
  function automatic logic hit_reg(input logic [7:0] addr, input logic [7:0] off);
    hit_reg = (addr[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  // stored words and their next values
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic [7:0] size_q;
  logic [7:0] size_d;
  logic [9:0] base_raw_q;
  logic [9:0] base_raw_d;
  logic [9:0] base_out_q;
  logic [9:0] base_out_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  wire wr_ctl = reg_wr && hit_reg(reg_addr, GAC_OFF_PORT_CONTROL);
  wire wr_size = reg_wr && hit_reg(reg_addr, GAC_OFF_SIZE_SELECT);
  wire wr_base = reg_wr && hit_reg(reg_addr, GAC_OFF_APERTURE_BASE);
  wire rd_ctl = hit_reg(reg_addr, GAC_OFF_PORT_CONTROL);
  wire rd_size = hit_reg(reg_addr, GAC_OFF_SIZE_SELECT);
  wire rd_base = hit_reg(reg_addr, GAC_OFF_APERTURE_BASE);

  // field views of the control and size select registers
  wire sync_en = ctl_q[GAC_CTL_SYNC_BIT];
  wire [1:0] thr_mode = ctl_q[GAC_CTL_THR_LSB +: 2];
  wire tlb_en = ctl_q[GAC_CTL_TLB_BIT];
  wire [5:0] size_mask = size_q[5:0];

  // only documented bits are stored, so reserved bits stay zero
  assign ctl_d = wr_ctl ? (reg_wdata & GAC_CTL_WMASK) : ctl_q;
  assign size_d = wr_size ? (reg_wdata[7:0] & GAC_SIZE_WMASK) : size_q;

  // masked base bits keep stale storage: once unmasked they show whatever
  // was left there, which software must overwrite before use
  assign base_raw_d = wr_base ? reg_wdata[31:GAC_BASE_LSB] : base_raw_q;

  // base bits 27:22 read zero where the size mask bit is zero; built from
  // next-state terms so the visible base can sit in a flop of its own
  assign base_out_d = {base_raw_d[9:6], base_raw_d[5:0] & size_d[5:0]};

  // read mux; unmapped addresses read as zero, and so does any cycle
  // without a read strobe
  assign rdata_d = !reg_rd ? 32'h0000_0000 :
                   rd_ctl ? ctl_q :
                   rd_size ? {24'h00_0000, size_q} :
                   rd_base ? {base_out_q, 22'h00_0000} :
                   32'h0000_0000;

  // ----------------------------------------------------------------------
  // register flops
  // ----------------------------------------------------------------------
  // control register; a write lands at the strobe edge, so a read in the
  // very next cycle already sees it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl_q <= GAC_CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // size select; reset leaves the mask zero, a 256 MB aperture
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      size_q <= GAC_SIZE_RESET;
    end else begin
      size_q <= size_d;
    end
  end

  // raw base storage is kept even where the size mask hides it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_raw_q <= GAC_BASE_RESET;
    end else begin
      base_raw_q <= base_raw_d;
    end
  end

  // visible base bits; the reset value agrees with the zero size mask
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_out_q <= GAC_BASE_RESET;
    end else begin
      base_out_q <= base_out_d;
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // aperture write synchronisation
  // ----------------------------------------------------------------------
  // with sync on a pending aperture write blocks the cycle and asks the
  // write buffer to drain; with sync off the cycle goes straight through
  // the hold is looked at again every clock, so a held cycle goes out in
  // the clock after the buffer reports empty
  wire sync_block = sync_en && aperture_writes_pending;
  wire go_d = cpu_port_cycle_req && !sync_block;
  wire drain_d = cpu_port_cycle_req && sync_block;
  logic go_q;
  logic drain_q;

  // the go flop carries both the sync hold and the free-running case
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_d;
    end
  end

  // drain request stands for as long as a cycle waits on posted writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      drain_q <= 1'b0;
    end else begin
      drain_q <= drain_d;
    end
  end

  // ----------------------------------------------------------------------
  // expedite throttle timer
  // ----------------------------------------------------------------------
  // throttle phase, position within it and the gated pending flag
  gac_thr_state_t thr_state_q;
  gac_thr_state_t thr_state_d;
  logic [7:0] thr_cnt_q;
  logic [7:0] thr_cnt_d;
  logic exp_q;

  // reserved codes are treated as no throttling, the safe reading
  // leaving mode 10 resets the pattern, so re-entry starts a full open phase
  wire thr_on = (thr_mode == GAC_THR_192_64);
  wire thr_last_on = (thr_cnt_q == GAC_THR_ON_CLKS - 8'h01);
  wire thr_last_off = (thr_cnt_q == GAC_THR_OFF_CLKS - 8'h01);

  // phase sequencing: idle, 192 clocks open, 64 clocks masked, repeat
  always_comb begin
    thr_state_d = thr_state_q;
    thr_cnt_d = thr_cnt_q + 8'h01;
    case (thr_state_q)
      GAC_TS_IDLE: begin
        thr_cnt_d = 8'h00;
        if (thr_on) begin
          thr_state_d = GAC_TS_ON;
        end
      end
      GAC_TS_ON: begin
        if (thr_last_on) begin
          thr_state_d = GAC_TS_MASK;
          thr_cnt_d = 8'h00;
        end
      end
      GAC_TS_MASK: begin
        if (thr_last_off) begin
          thr_state_d = GAC_TS_ON;
          thr_cnt_d = 8'h00;
        end
      end
      default: begin
        thr_state_d = GAC_TS_IDLE;
        thr_cnt_d = 8'h00;
      end
    endcase
    if (!thr_on) begin
      thr_state_d = GAC_TS_IDLE;
      thr_cnt_d = 8'h00;
    end
  end

  // requests are never dropped: only the pending indication is hidden,
  // so the stream resumes as soon as the masked phase ends
  wire exp_d = expedite_pending_raw && (thr_state_q != GAC_TS_MASK);

  // phase and count flops; both drop back to idle on reset or on leaving mode 10
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      thr_state_q <= GAC_TS_IDLE;
      thr_cnt_q <= 8'h00;
    end else begin
      thr_state_q <= thr_state_d;
      thr_cnt_q <= thr_cnt_d;
    end
  end

  // gated pending flag, one clock behind the raw indication
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= exp_d;
    end
  end

  // ----------------------------------------------------------------------
  // graphics translation lookaside buffer
  // ----------------------------------------------------------------------
  // entry arrays; hit_frame chains a one-hot OR across the entries
  logic [GAC_TLB_ENTRIES-1:0] ent_valid_q;
  logic [GAC_PAGE_W-1:0] ent_page_q [GAC_TLB_ENTRIES];
  logic [GAC_FRAME_W-1:0] ent_frame_q [GAC_TLB_ENTRIES];
  logic [1:0] victim_q;
  gac_answer_t answer_q;
  gac_answer_t answer_d;
  logic [GAC_TLB_ENTRIES-1:0] ent_match;
  logic [GAC_FRAME_W-1:0] hit_frame [GAC_TLB_ENTRIES+1];

  // fills are accepted only while the buffer runs
  // a fill serves lookups from the next clock on, never in its own cycle
  wire fill_take = tlb_en && tlb_fill.valid;

  // per-entry compare and one-hot frame select
  // duplicate fills of one page would OR their frames; callers avoid them
  assign hit_frame[0] = '0;
  genvar gi;
  generate
    for (gi = 0; gi < GAC_TLB_ENTRIES; gi++) begin : g_ent
      assign ent_match[gi] = ent_valid_q[gi] && (ent_page_q[gi] == tlb_lookup.page);
      assign hit_frame[gi+1] = hit_frame[gi] | (ent_match[gi] ? ent_frame_q[gi] : '0);

      // entry store; a disabled buffer holds every valid flag cleared
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ent_valid_q[gi] <= 1'b0;
          ent_page_q[gi] <= '0;
          ent_frame_q[gi] <= '0;
        end else if (!tlb_en) begin
          ent_valid_q[gi] <= 1'b0;
        end else if (fill_take && victim_q == 2'(gi)) begin
          ent_valid_q[gi] <= 1'b1;
          ent_page_q[gi] <= tlb_fill.page;
          ent_frame_q[gi] <= tlb_fill.frame;
        end
      end
    end
  endgenerate

  // answer one cycle after a lookup; disabled means bypass, never a hit
  // the frame reads zero on a miss so no stale translation leaks out
  assign answer_d.valid = tlb_lookup.valid;
  assign answer_d.hit = tlb_lookup.valid && tlb_en && (|ent_match);
  assign answer_d.bypass = tlb_lookup.valid && !tlb_en;
  assign answer_d.frame = answer_d.hit ? hit_frame[GAC_TLB_ENTRIES] : '0;

  // round-robin replacement keeps the logic small at the cost of hit rate
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      victim_q <= 2'h0;
    end else begin
      victim_q <= fill_take ? victim_q + 2'h1 : victim_q;
    end
  end

  // answer register; a lookup is answered exactly one clock later
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      answer_q <= '0;
    end else begin
      answer_q <= answer_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // every output below is a flop or a plain slice of one
  assign reg_rdata = rdata_q;
  assign cpu_port_cycle_go = go_q;
  assign aperture_drain_req = drain_q;
  assign expedite_pending = exp_q;
  assign tlb_answer = answer_q;
  assign aperture_base_bits = base_out_q;
  assign aperture_size_mask = size_mask;
  assign graphics_translation_buffer_en = ctl_q[GAC_CTL_TLB_BIT];

endmodule

// File: testbench/gac_top_properties.sv
/*
  Checker for gac_top: port-level timing of sync, translation buffer,
  size mask and throttle gating.
  Assumes it is bound into gac_top and sees only that module's ports.
*/
module gac_top_chk
  import gac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic aperture_writes_pending,
  input wire logic cpu_port_cycle_req,
  input wire logic cpu_port_cycle_go,
  input wire logic aperture_drain_req,
  input wire logic expedite_pending_raw,
  input wire logic expedite_pending,
  input wire gac_pkg::gac_lookup_t tlb_lookup,
  input wire gac_pkg::gac_fill_t tlb_fill,
  input wire gac_pkg::gac_answer_t tlb_answer,
  input wire logic [9:0] aperture_base_bits,
  input wire logic [5:0] aperture_size_mask,
  input wire logic graphics_translation_buffer_en
);
  // ----------------------------------------------------------------
  // shadow state and properties
  // ----------------------------------------------------------------
  // the sync bit has no port of its own, so track it from the writes
  logic sync_q;
  always_ff @(posedge ref_clk) begin
    if (srst) sync_q <= 1'b0;
    else if (reg_wr && reg_addr == GAC_OFF_PORT_CONTROL) sync_q <= reg_wdata[GAC_CTL_SYNC_BIT];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_sync_hold;
    cpu_port_cycle_req && sync_q && aperture_writes_pending |=>
      !cpu_port_cycle_go && aperture_drain_req;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("cycle over pending writes");
  property p_nosync_go;
    cpu_port_cycle_req && !sync_q |=> cpu_port_cycle_go;
  endproperty
  a_nosync_go: assert property (p_nosync_go) else $error("port cycle withheld");
  property p_tlb_en;
    reg_wr && reg_addr == GAC_OFF_PORT_CONTROL |=>
      graphics_translation_buffer_en == $past(reg_wdata[GAC_CTL_TLB_BIT]);
  endproperty
  a_tlb_en: assert property (p_tlb_en) else $error("buffer enable not updated");
  property p_tlb_bypass;
    tlb_lookup.valid && !graphics_translation_buffer_en |=>
      tlb_answer.valid && tlb_answer.bypass && !tlb_answer.hit;
  endproperty
  a_tlb_bypass: assert property (p_tlb_bypass) else $error("lookup did not bypass");
  property p_base_mask;
    (aperture_base_bits[5:0] & ~aperture_size_mask) == 6'h00;
  endproperty
  a_base_mask: assert property (p_base_mask) else $error("masked base bit set");
  property p_size_wr;
    reg_wr && reg_addr == GAC_OFF_SIZE_SELECT |=> aperture_size_mask == $past(reg_wdata[5:0]);
  endproperty
  a_size_wr: assert property (p_size_wr) else $error("size field not updated");
  property p_reset_size;
    $fell(srst) |-> aperture_size_mask == 6'h00 && aperture_base_bits[5:0] == 6'h00;
  endproperty
  a_reset_size: assert property (p_reset_size) else $error("size not zero after reset");
  property p_rsvd_rd;
    $past(reg_rd) && $past(reg_addr) == GAC_OFF_PORT_CONTROL |->
      (reg_rdata & ~GAC_CTL_WMASK) == 32'h0000_0000;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved control bit read high");
  property p_exp_gate;
    expedite_pending |-> $past(expedite_pending_raw);
  endproperty
  a_exp_gate: assert property (p_exp_gate) else $error("expedite without request");
  c_drain: cover property (aperture_drain_req);
  c_hit: cover property (tlb_answer.valid && tlb_answer.hit);
  c_mask: cover property ($past(expedite_pending_raw) && !expedite_pending);
endmodule

bind gac_top gac_top_chk chk_u (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .aperture_writes_pending(aperture_writes_pending), .cpu_port_cycle_req(cpu_port_cycle_req),
  .cpu_port_cycle_go(cpu_port_cycle_go), .aperture_drain_req(aperture_drain_req),
  .expedite_pending_raw(expedite_pending_raw), .expedite_pending(expedite_pending),
  .tlb_lookup(tlb_lookup), .tlb_fill(tlb_fill), .tlb_answer(tlb_answer),
  .aperture_base_bits(aperture_base_bits), .aperture_size_mask(aperture_size_mask),
  .graphics_translation_buffer_en(graphics_translation_buffer_en));

// File: testbench/tb.sv
/*
  Self-checking bench for gac_top: register access, sync, buffer,
  size mask and throttle, driven through the block's own ports.
  Assumes the checker file is compiled alongside.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gac_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and checks
  // ----------------------------------------------------------------
  logic ref_clk, srst, reg_wr, reg_rd, pend, req, raw, go, drain, exp_p, tlb_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [9:0] base;
  logic [5:0] size;
  gac_lookup_t lu;
  gac_fill_t fi;
  gac_answer_t an;
  int n_mismatch = 0;
  int n_tests = 0;
  int z;
  logic [5:0] pats [7] = '{6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20, 6'h00};
  gac_top dut_u (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aperture_writes_pending(pend),
    .cpu_port_cycle_req(req), .cpu_port_cycle_go(go), .aperture_drain_req(drain),
    .expedite_pending_raw(raw), .expedite_pending(exp_p), .tlb_lookup(lu), .tlb_fill(fi),
    .tlb_answer(an), .aperture_base_bits(base), .aperture_size_mask(size),
    .graphics_translation_buffer_en(tlb_en));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  task automatic fl(input logic [15:0] p, input logic [19:0] f);
    @(posedge ref_clk);
    fi <= {1'b1, p, f};
    @(posedge ref_clk);
    fi.valid <= 1'b0;
  endtask
  // e holds valid, hit, bypass; the frame is only meaningful on a hit
  task automatic lk(input logic [15:0] p, input logic [2:0] e, input logic [19:0] f);
    @(posedge ref_clk);
    lu <= {1'b1, p};
    @(posedge ref_clk);
    lu.valid <= 1'b0;
    #1 cmp({29'h0, an.valid, an.hit, an.bypass}, {29'h0, e});
    if (e[1]) cmp({12'h0, an.frame}, {12'h0, f});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hang is cut short well past the longest sequence
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {srst, reg_wr, reg_rd, pend, req, raw} = 6'b100000;
    {reg_addr, reg_wdata, lu, fi} = '0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rdc(GAC_OFF_PORT_CONTROL, GAC_CTL_RESET);
    rdc(GAC_OFF_SIZE_SELECT, 32'h0);
    cmp({22'h0, base}, 32'h0);
    wr(GAC_OFF_PORT_CONTROL, 32'hffff_ffff);
    rdc(GAC_OFF_PORT_CONTROL, 32'h0000_2380);
    wr(GAC_OFF_SIZE_SELECT, 32'hffff_ffff);
    rdc(GAC_OFF_SIZE_SELECT, 32'h0000_003f);
    rdc(8'h40, 32'h0);
    $display("test registers done");
    wr(GAC_OFF_PORT_CONTROL, 32'h0000_2000);
    @(posedge ref_clk);
    pend <= 1'b1;
    req <= 1'b1;
    #1 @(posedge ref_clk);
    #1 cmp({30'h0, go, drain}, 32'h1);
    @(posedge ref_clk);
    pend <= 1'b0;
    #1 @(posedge ref_clk);
    #1 cmp({30'h0, go, drain}, 32'h2);
    wr(GAC_OFF_PORT_CONTROL, 32'h0);
    @(posedge ref_clk);
    pend <= 1'b1;
    #1 @(posedge ref_clk);
    #1 cmp({30'h0, go, drain}, 32'h2);
    @(posedge ref_clk);
    {pend, req} <= 2'b00;
    $display("test sync done");
    fl(16'h5, 20'ha);
    lk(16'h5, 3'b101, 20'h0);
    wr(GAC_OFF_PORT_CONTROL, 32'h80);
    #1 cmp({31'h0, tlb_en}, 32'h1);
    lk(16'h5, 3'b100, 20'h0);
    fl(16'h5, 20'ha);
    lk(16'h5, 3'b110, 20'ha);
    wr(GAC_OFF_PORT_CONTROL, 32'h0);
    wr(GAC_OFF_PORT_CONTROL, 32'h80);
    lk(16'h5, 3'b100, 20'h0);
    $display("test buffer done");
    // base bits are rewritten after every size change, as software must
    foreach (pats[i]) begin
      wr(GAC_OFF_SIZE_SELECT, {26'h0, pats[i]});
      wr(GAC_OFF_APERTURE_BASE, 32'hffc0_0000);
      #1 cmp({22'h0, base}, {22'h0, 4'hf, pats[i]});
      cmp({26'h0, size}, {26'h0, pats[i]});
      rdc(GAC_OFF_APERTURE_BASE, {4'hf, pats[i], 22'h0});
    end
    $display("test size done");
    @(posedge ref_clk);
    raw <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(GAC_OFF_PORT_CONTROL, 32'(m) << 8);
      z = 0;
      repeat (300) begin
        @(posedge ref_clk);
        #1 if (exp_p !== 1'b1) z++;
      end
      cmp(32'(z), (m == 2) ? 32'd64 : 32'd0);
    end
    $display("test throttle done");
    wrap_up();
  end
endmodule
